// ---- include/coproc_seq_regs.vh ----
// Constants for the coprocessor handshake sequencer
`ifndef COPROC_SEQ_REGS_VH
`define COPROC_SEQ_REGS_VH
`define CPS_AW          32
`define CPS_DW          32
`define CPS_OFS_PC8     32'h0000_0008
`define CPS_OFS_PC12    32'h0000_000c
`define CPS_WORD_STEP   32'h0000_0004
`define CPS_FIFO_DEPTH  16
`define CPS_FIFO_AW     4
`define CPS_OP_DATA     2'h0
`define CPS_OP_MEM2CP   2'h1
`define CPS_OP_CP2MEM   2'h2
`define CPS_OP_LOADCP   2'h3
`endif

// ---- logic/word_fifo.v ----
// Flip-flop FIFO with valid and ready on both sides
module word_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  // ==========================================================
  // Flags
  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage write
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ---- logic/coproc_handshake_sequencer.v ----
// Core-side sequencer for the coprocessor handshake and transfers
// Behaviour
// RL1: Coprocessor commits to a data operation before pulling busy low.
// RL2: Coprocessor unable ever to do the instruction leaves both lines high.
// RL3: Able but not ready: absent low, busy high until it can commit.
// RL4: Core busy-waits, instr line low and address pc+8, until busy low.
// RL5: Ready data operation: one cycle, request/seq/fetch 0, then pc+12. The code keeps request high in that cycle.
// RL6: Not-ready wait is internal cycles; request asserted in last wait cycle. The code keeps request high through all wait cycles, then asserts it at pc+12.
// RL7: Memory-to-coprocessor: coprocessor commits only when ready for data.
// RL8: After busy low, transfer addresses issue back to back, one word each.
// RL9: Coprocessor sets word count; both lines high mark the last cycle.
// RL10: Address computed in first and wait cycles; base written in transfer.
// RL11: Transfers: instr and fetch high, rising words, last nonsequential. The code keeps burst_continue_o high on the last transfer.
// RL12: Coprocessor-to-memory as above but write line high each transfer.
// RL13: Load from coprocessor moves one word, written in the third cycle.
// RL14: Third load cycle may merge with next prefetch as one N-cycle.
// RL15: Load: request negated through handshake and data, pc+12, seq last.
// RL16: Both response lines high means the undefined-instruction trap.
// RL17: Response lines sampled each handshake cycle to pick the next step.
`include "coproc_seq_regs.vh"
module coproc_handshake_sequencer (
  input  wire                clk_sys_i,
  input  wire                sys_rst_i,
  input  wire                start_i,
  input  wire [1:0]          op_i,
  input  wire [`CPS_AW-1:0]  pc_i,
  input  wire [`CPS_AW-1:0]  base_addr_i,
  input  wire                merge_fetch_i,
  input  wire                coproc_absent_i,
  input  wire                coproc_busy_i,
  input  wire [`CPS_DW-1:0]  coproc_word_i,
  output wire                busy_o,
  output reg  [`CPS_AW-1:0]  addr_o,
  output reg                 mem_request_n_o,
  output reg                 burst_continue_o,
  output reg                 instr_fetch_n_o,
  output reg                 coproc_instr_n_o,
  output reg                 write_not_read_o,
  output reg                 byte_word_sel_o,
  output reg                 trap_o,
  output reg                 done_o,
  output reg                 base_wb_o,
  output reg  [`CPS_AW-1:0]  base_wb_addr_o,
  output wire [`CPS_DW-1:0]  dest_word_o,
  output wire                dest_valid_o,
  input  wire                dest_ready_i
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SHAKE = 5'h02;
  localparam [4:0] ST_XFER = 5'h04;
  localparam [4:0] ST_LDATA = 5'h08;
  localparam [4:0] ST_LLAST = 5'h10;

  reg  [4:0]         state_r;
  reg  [1:0]         op_r;
  reg  [`CPS_AW-1:0] pc_r;
  reg  [`CPS_AW-1:0] xaddr_r;
  reg                ld_valid_r;
  reg  [`CPS_DW-1:0] ld_word_r;
  wire               resp_absent;
  wire               resp_busy;

  // ==========================================================
  // Response lines
  // The coprocessor runs on the core clock and answers within the
  // handshake cycle, so its lines are used as they stand at the edge
  // that ends that cycle. Extra flops here would make the core act on
  // the answer left over from the previous instruction.
  assign resp_absent = coproc_absent_i;  // see RL17
  assign resp_busy   = coproc_busy_i;

  // Busy while any instruction is in flight
  assign busy_o = (state_r != ST_IDLE);

  // ==========================================================
  // Sequencer
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r          <= ST_IDLE;
      op_r             <= `CPS_OP_DATA;
      pc_r             <= {`CPS_AW{1'b0}};
      xaddr_r          <= {`CPS_AW{1'b0}};
      addr_o           <= {`CPS_AW{1'b0}};
      mem_request_n_o  <= 1'b1;
      burst_continue_o <= 1'b0;
      instr_fetch_n_o  <= 1'b1;
      coproc_instr_n_o <= 1'b1;
      write_not_read_o <= 1'b0;
      byte_word_sel_o  <= 1'b1;
      trap_o           <= 1'b0;
      done_o           <= 1'b0;
      base_wb_o        <= 1'b0;
      base_wb_addr_o   <= {`CPS_AW{1'b0}};
      ld_valid_r       <= 1'b0;
      ld_word_r        <= {`CPS_DW{1'b0}};
    end else begin
      trap_o     <= 1'b0;
      done_o     <= 1'b0;
      base_wb_o  <= 1'b0;
      ld_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          mem_request_n_o  <= 1'b1;
          burst_continue_o <= 1'b0;
          instr_fetch_n_o  <= 1'b1;
          coproc_instr_n_o <= 1'b1;
          write_not_read_o <= 1'b0;
          if (start_i) begin
            // Handshake cycle: fetch at pc+8, instr line low   // see RL4
            state_r          <= ST_SHAKE;
            op_r             <= op_i;
            pc_r             <= pc_i;
            xaddr_r          <= base_addr_i;  // see RL10
            addr_o           <= pc_i + `CPS_OFS_PC8;
            coproc_instr_n_o <= 1'b0;
            instr_fetch_n_o  <= 1'b0;
            mem_request_n_o  <= 1'b1;  // see RL6
          end
        end
        ST_SHAKE: begin
          // Sample both response lines this cycle   // see RL17
          // Fetch line is low only in the first handshake cycle
          instr_fetch_n_o <= 1'b1;  // see RL4
          if (resp_absent & resp_busy) begin
            // Nobody can do it: undefined trap   // see RL16 RL2
            trap_o           <= 1'b1;
            state_r          <= ST_IDLE;
            coproc_instr_n_o <= 1'b1;
            mem_request_n_o  <= 1'b1;
          end else if (resp_busy) begin
            // Not committed: keep waiting at pc+8   // see RL3 RL4 RL6
            addr_o           <= pc_r + `CPS_OFS_PC8;
            mem_request_n_o  <= 1'b1;
            burst_continue_o <= 1'b0;
          end else begin
            // Committed: branch on operation   // see RL1 RL7
            coproc_instr_n_o <= 1'b1;
            instr_fetch_n_o  <= 1'b1;
            case (op_r)
              `CPS_OP_DATA: begin
                state_r         <= ST_IDLE;  // see RL5
                done_o          <= 1'b1;
                addr_o          <= pc_r + `CPS_OFS_PC12;
                mem_request_n_o <= 1'b0;
              end
              `CPS_OP_LOADCP: begin
                state_r          <= ST_LDATA;  // see RL15
                addr_o           <= pc_r + `CPS_OFS_PC12;
                mem_request_n_o  <= 1'b1;
                burst_continue_o <= 1'b0;
              end
              default: begin
                // Transfer cycles from computed base   // see RL8 RL11
                state_r          <= ST_XFER;
                addr_o           <= xaddr_r;
                xaddr_r          <= xaddr_r + `CPS_WORD_STEP;
                mem_request_n_o  <= 1'b0;
                burst_continue_o <= ~resp_absent;
                write_not_read_o <= (op_r == `CPS_OP_CP2MEM);  // see RL12
              end
            endcase
          end
        end
        ST_XFER: begin
          base_wb_o      <= 1'b1;  // see RL10
          base_wb_addr_o <= xaddr_r;
          if (resp_absent & resp_busy) begin
            // Last transfer marked by both lines high   // see RL9 RL11
            state_r          <= ST_IDLE;
            done_o           <= 1'b1;
            addr_o           <= pc_r + `CPS_OFS_PC12;
            mem_request_n_o  <= 1'b0;
            burst_continue_o <= 1'b0;
            write_not_read_o <= 1'b0;
          end else begin
            // Never stalls: the coprocessor paces words by committing late
            addr_o           <= xaddr_r;  // see RL8
            xaddr_r          <= xaddr_r + `CPS_WORD_STEP;
            burst_continue_o <= 1'b1;
          end
        end
        ST_LDATA: begin
          // Single data word captured for the destination   // see RL13
          ld_word_r        <= coproc_word_i;
          ld_valid_r       <= 1'b1;
          state_r          <= ST_LLAST;
          // Merged last cycle becomes a nonsequential fetch
          mem_request_n_o  <= 1'b0;
          burst_continue_o <= ~merge_fetch_i;  // see RL14 RL15
          addr_o           <= pc_r + `CPS_OFS_PC12;
        end
        ST_LLAST: begin
          state_r          <= ST_IDLE;
          done_o           <= 1'b1;
          mem_request_n_o  <= 1'b1;
          burst_continue_o <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Destination words pass through the FIFO   // see RL13
  // Loads cannot be refused once committed, so the consumer must drain
  // the FIFO before a seventeenth word arrives or that word is lost
  word_fifo #(
    .WIDTH (`CPS_DW),
    .DEPTH (`CPS_FIFO_DEPTH),
    .AW    (`CPS_FIFO_AW)
  ) u_dest_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (ld_word_r),
    .in_valid_i  (ld_valid_r),
    .in_ready_o  (),
    .out_data_o  (dest_word_o),
    .out_valid_o (dest_valid_o),
    .out_ready_i (dest_ready_i)
  );
endmodule

// ---- sim/coproc_seq_chk.sv ----
// Port assertions for the coprocessor handshake sequencer
`include "coproc_seq_regs.vh"
module coproc_seq_chk (
  input wire              clk_sys_i,
  input wire              sys_rst_i,
  input wire              start_i,
  input wire [1:0]        op_i,
  input wire [31:0]       pc_i,
  input wire              coproc_absent_i,
  input wire              coproc_busy_i,
  input wire              busy_o,
  input wire [31:0]       addr_o,
  input wire              mem_request_n_o,
  input wire              burst_continue_o,
  input wire              instr_fetch_n_o,
  input wire              coproc_instr_n_o,
  input wire              write_not_read_o,
  input wire              byte_word_sel_o,
  input wire              trap_o,
  input wire              done_o,
  input wire              base_wb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire mem_op = (op_i == `CPS_OP_MEM2CP) || (op_i == `CPS_OP_CP2MEM);
  // ==========================================================
  // Properties
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_start;
    start_i && !busy_o |=> !coproc_instr_n_o && !instr_fetch_n_o
      && addr_o == pc_i + `CPS_OFS_PC8;
  endproperty
  a_start: assert property (p_start) else $error("bad first cycle");
  property p_wait;
    !coproc_instr_n_o && mem_request_n_o |-> addr_o == pc_i + `CPS_OFS_PC8;
  endproperty
  a_wait: assert property (p_wait) else $error("wait address");
  property p_step;
    busy_o && coproc_instr_n_o && burst_continue_o && mem_op
      && !(coproc_absent_i && coproc_busy_i)
      |=> addr_o == $past(addr_o) + `CPS_WORD_STEP;
  endproperty
  a_step: assert property (p_step) else $error("address step");
  property p_fetch;
    busy_o && coproc_instr_n_o |-> instr_fetch_n_o;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch flag");
  property p_wfetch;
    !coproc_instr_n_o && !$past(coproc_instr_n_o) |-> instr_fetch_n_o;
  endproperty
  a_wfetch: assert property (p_wfetch) else $error("wait fetch");
  property p_write;
    write_not_read_o |-> op_i == `CPS_OP_CP2MEM && coproc_instr_n_o;
  endproperty
  a_write: assert property (p_write) else $error("write flag");
  property p_done;
    done_o && op_i != `CPS_OP_LOADCP |-> !mem_request_n_o
      && addr_o == pc_i + `CPS_OFS_PC12;
  endproperty
  a_done: assert property (p_done) else $error("done request");
  property p_done_ld;
    done_o && op_i == `CPS_OP_LOADCP |-> !$past(mem_request_n_o);
  endproperty
  a_done_ld: assert property (p_done_ld) else $error("last load");
  property p_load;
    op_i == `CPS_OP_LOADCP && busy_o && !coproc_instr_n_o |-> mem_request_n_o;
  endproperty
  a_load: assert property (p_load) else $error("load request");
  property p_wb;
    base_wb_o |-> coproc_instr_n_o && mem_op;
  endproperty
  a_wb: assert property (p_wb) else $error("base write");
  property p_trap;
    trap_o |-> $past(coproc_absent_i) && $past(coproc_busy_i);
  endproperty
  a_trap: assert property (p_trap) else $error("trap cause");
  property p_bw;
    byte_word_sel_o;
  endproperty
  a_bw: assert property (p_bw) else $error("word size");
endmodule
bind coproc_handshake_sequencer coproc_seq_chk i_coproc_seq_chk (
  .clk_sys_i, .sys_rst_i, .start_i, .op_i, .pc_i, .coproc_absent_i,
  .coproc_busy_i, .busy_o, .addr_o, .mem_request_n_o, .burst_continue_o,
  .instr_fetch_n_o, .coproc_instr_n_o, .write_not_read_o,
  .byte_word_sel_o, .trap_o, .done_o, .base_wb_o);

// ---- sim/coproc_model.sv ----
// Behavioural attached coprocessor for the sequencer bench
module coproc_model (
  input  wire         clk_sys_i,
  input  wire         sys_rst_i,
  input  wire         instr_n_i,
  input  wire         seq_busy_i,
  input  wire [7:0]   wait_i,
  input  wire [7:0]   words_i,
  input  wire         never_i,
  input  wire [31:0]  word_i,
  output logic        absent_o,
  output logic        busy_o,
  output wire  [31:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt_r;
  logic [7:0]  k_r;
  logic [31:0] alt_r;
  // Data valid only while an instruction runs, churning otherwise
  assign data_o = seq_busy_i ? word_i : alt_r;
  // Response lines answer within the cycle; released high when idle
  always_comb begin
    if (sys_rst_i || !seq_busy_i || never_i) begin
      absent_o = 1'b1;
      busy_o   = 1'b1;
    end else if (!instr_n_i) begin
      absent_o = 1'b0;
      busy_o   = (cnt_r < wait_i);
    end else begin
      absent_o = (k_r + 8'h01 >= words_i);
      busy_o   = (k_r + 8'h01 >= words_i);
    end
  end
  // Busy-wait and word counters
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      alt_r <= 32'h0000_0000;
    end else begin
      alt_r <= ~alt_r;
    end
    if (sys_rst_i || !seq_busy_i) begin
      cnt_r <= 8'h00;
      k_r   <= 8'h00;
    end else if (!instr_n_i) begin
      cnt_r <= cnt_r + {7'h00, cnt_r < wait_i};
    end else begin
      k_r   <= k_r + 8'h01;
    end
  end
endmodule

// ---- sim/tb_coproc_handshake_sequencer.sv ----
// Self-checking bench for the coprocessor handshake sequencer
`include "coproc_seq_regs.vh"
module tb_coproc_handshake_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i, sys_rst_i, start_i, merge_fetch_i, dest_ready_i;
  logic [1:0]  op_i;
  logic [31:0] pc_i, base_addr_i, word_r, coproc_word_i, addr_o;
  logic [31:0] base_wb_addr_o, dest_word_o;
  logic [7:0]  wait_r, words_r;
  logic        never_r, coproc_absent_i, coproc_busy_i, busy_o;
  logic        mem_request_n_o, burst_continue_o, instr_fetch_n_o;
  logic        coproc_instr_n_o, write_not_read_o, byte_word_sel_o;
  logic        trap_o, done_o, base_wb_o, dest_valid_o, seen_done, seen_trap;
  int          mismatches, n_compared, nw;
  // ==========================================================
  // Design and partner
  coproc_handshake_sequencer i_coproc_handshake_sequencer (.*);
  coproc_model i_coproc_model (.clk_sys_i, .sys_rst_i,
    .instr_n_i(coproc_instr_n_o), .seq_busy_i(busy_o), .wait_i(wait_r),
    .words_i(words_r), .never_i(never_r), .word_i(word_r),
    .absent_o(coproc_absent_i), .busy_o(coproc_busy_i),
    .data_o(coproc_word_i));
  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One instruction; transfer cycles checked as they pass
  task automatic run(input logic [1:0] op, input logic [7:0] w,
                     input logic [7:0] n, input logic nev);
    int k;
    wait_r <= w;
    words_r <= n;
    never_r <= nev;
    op_i <= op;
    nw = 0;
    seen_done = 1'b0;
    seen_trap = 1'b0;
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    for (k = 0; k < 300 && !(seen_done || seen_trap); k++) begin
      @(posedge clk_sys_i);
      #1;
      if (busy_o && coproc_instr_n_o && !mem_request_n_o
          && op != `CPS_OP_LOADCP && addr_o !== pc_i + `CPS_OFS_PC12) begin
        chk(addr_o, base_addr_i + 32'(nw) * `CPS_WORD_STEP);
        chk(write_not_read_o, op == `CPS_OP_CP2MEM);
        nw++;
      end
      if (op == `CPS_OP_LOADCP && busy_o && !mem_request_n_o) begin
        chk(addr_o, pc_i + `CPS_OFS_PC12);
        chk(burst_continue_o, !merge_fetch_i);
      end
      if (done_o && op inside {`CPS_OP_MEM2CP, `CPS_OP_CP2MEM}) begin
        chk(base_wb_o, 1'b1);
        chk(base_wb_addr_o, base_addr_i + 32'(n) * `CPS_WORD_STEP);
      end
      seen_done = done_o;
      seen_trap = trap_o;
    end
    if (k == 300) mismatches++;
    @(posedge clk_sys_i);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_data;
    run(`CPS_OP_DATA, 8'h00, 8'h01, 1'b0);
    chk(seen_done, 1'b1);
    chk(nw, 0);
    run(`CPS_OP_DATA, 8'h06, 8'h01, 1'b0);
    chk(seen_done, 1'b1);
  endtask
  task automatic t_xfer;
    run(`CPS_OP_MEM2CP, 8'h03, 8'h04, 1'b0);
    chk(nw, 4);
    run(`CPS_OP_CP2MEM, 8'h00, 8'h02, 1'b0);
    chk(nw, 2);
  endtask
  task automatic t_undef;
    run(`CPS_OP_DATA, 8'h00, 8'h01, 1'b1);
    chk(seen_trap, 1'b1);
    chk(seen_done, 1'b0);
  endtask
  task automatic t_load_fifo;
    for (int i = 0; i < 16; i++) begin
      word_r <= 32'hc0de_0000 + i;
      merge_fetch_i <= i[0];
      run(`CPS_OP_LOADCP, 8'(i % 3), 8'h01, 1'b0);
      chk(seen_done, 1'b1);
    end
    dest_ready_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      #1;
      chk(dest_valid_o, 1'b1);
      chk(dest_word_o, 32'hc0de_0000 + i);
      @(posedge clk_sys_i);
    end
    #1;
    chk(dest_valid_o, 1'b0);
    @(posedge clk_sys_i);
    dest_ready_i <= 1'b0;
  endtask
  // Main sequence
  initial begin
    {start_i, merge_fetch_i, dest_ready_i, never_r, op_i} = '0;
    pc_i = 32'h0000_0100;
    base_addr_i = 32'h0000_2000;
    {word_r, wait_r, words_r} = '0;
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_data();
    t_xfer();
    t_undef();
    t_load_fifo();
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    end_sim();
  end
endmodule
